// ==== drawing_display_defs.vh ====
// Notes on behaviour
// - Drawing soft reset is 1 after reset.
// - Soft reset 0 lets commands run.
// - Soft reset clears drawing only, not display.
// - Soft reset clears four drawing flags.
// - Display reset stays 1 while reset pin low.
// - State 00 outputs display-off value.
// - State 01 outputs frame memory next frame.
// - State 10 does refresh only.
// - State 10 blocks drawing despite render start.
// - State 10 drives display data zero.
// - State 10 holds vertical blank flag clear.
// - State 10 waits frame memory unless capture.
// - State 11 forbidden; drives the same outputs as state 10.
// - Reset sets both resets, clears lower and burst.
`ifndef DRAWING_DISPLAY_DEFS_VH
`define DRAWING_DISPLAY_DEFS_VH
// Register word addresses.
`define ADDR_SYSTEM_CONTROL 4'h0
`define ADDR_DRAW_STATUS 4'h1
`define ADDR_DISPLAY_CFG 4'h2
`define ADDR_DISPLAY_STATE 4'h3
// Field positions in the system control register.
`define BIT_SOFT_RESET 15
`define BIT_DISPLAY_RESET 14
`define BIT_DISPLAY_ENABLE 13
`define BIT_RENDER_BREAK 10
`define BIT_DISPLAY_CHANGE 9
`define BIT_RENDER_START 8
`define BIT_BURST_HI 7
`define BIT_BURST_LO 6
// Field positions in the drawing status register.
`define BIT_CMD_ERROR 0
`define BIT_TRAP 1
`define BIT_CMD_SUSPEND 2
`define BIT_DRAW_BREAK 3
`define BIT_VBLANK 4
// Field positions in the display configuration register.
`define BIT_CAPTURE_EN 0
// Reset value of the system control register, burst bits excluded.
`define SYSCTL_RESET 16'hC000
// Soft reset hold time in cycles.
`define SOFT_RESET_MIN_CYCLES 16
// Display state encodings, reset then enable.
`define DSTATE_RUN_OFF 2'h0
`define DSTATE_RUN_ON 2'h1
`define DSTATE_REFRESH 2'h2
`define DSTATE_BAD 2'h3
`endif

// ==== frame_sync.v ====
// Marks frame starts by counting cycles per frame.
module frame_sync #(
  parameter FRAME_CYCLES = 1024
) (
  input wire clk, // System clock.
  input wire arst_n, // Asynchronous reset, active low.
  input wire run, // Counts only while display runs.
  output reg frame_start, // Pulse at the first cycle of a frame.
  output reg vblank // High in the last eighth of a frame.
);
  // Position within the current frame.
  reg [15:0] count;
  // Counts frame position and flags frame starts.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= 16'h0000;
      frame_start <= 1'b0;
      vblank <= 1'b0;
    end
    else if (!run)
    begin
      // Stopped display holds at the top of a frame.
      count <= 16'h0000;
      frame_start <= 1'b0;
      vblank <= 1'b0;
    end
    else
    begin
      if (count == FRAME_CYCLES[15:0] - 16'h0001)
        count <= 16'h0000;
      else
        count <= count + 16'h0001;
      frame_start <= (count == FRAME_CYCLES[15:0] - 16'h0001);
      vblank <= (count >= (FRAME_CYCLES[15:0] - (FRAME_CYCLES[15:0] >> 3)));
    end
  end
endmodule // frame_sync

// ==== soft_reset_timer.v ====
// Counts how long the drawing soft reset has been held.
module soft_reset_timer #(
  parameter MIN_CYCLES = 16
) (
  input wire clk, // System clock.
  input wire arst_n, // Asynchronous reset, active low.
  input wire hold, // Soft reset bit level.
  output reg done // High once the hold reached its minimum.
);
  // Cycles of the current hold, saturating.
  reg [7:0] count;
  // Counts the hold and restarts when the bit falls.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= 8'h00;
      done <= 1'b0;
    end
    else if (!hold)
    begin
      count <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      if (count != MIN_CYCLES[7:0])
        count <= count + 8'h01;
      done <= (count >= MIN_CYCLES[7:0] - 8'h01);
    end
  end
endmodule // soft_reset_timer

// ==== drawing_display_reset_control.v ====
// The Avalon-MM interface to the registers was decided locally.
`include "drawing_display_defs.vh"
// Upper system control bits: drawing soft reset and display state.
module drawing_display_reset_control #(
  parameter FRAME_CYCLES = 1024,
  parameter PIXEL_WIDTH = 16
) (
  input wire clk, // System clock, 10 MHz.
  input wire arst_n, // Asynchronous reset, active low.
  input wire reset_pin_n, // Hardware reset pin level, active low.
  input wire [3:0] avs_address, // Avalon word address.
  input wire avs_read, // Avalon read request.
  input wire avs_write, // Avalon write request.
  input wire [31:0] avs_writedata, // Avalon write data.
  output reg [31:0] avs_readdata, // Avalon read data.
  output reg avs_waitrequest, // Avalon wait, low when answered.
  input wire cmd_error_evt, // Drawing engine raises command error.
  input wire trap_evt, // Drawing engine hits a trap command.
  input wire cmd_suspend_evt, // Drawing engine suspends a command.
  input wire draw_break_evt, // Drawing engine takes a break.
  input wire render_started, // Drawing engine took the start request.
  input wire display_changed, // Display buffer switch done.
  input wire [PIXEL_WIDTH-1:0] frame_pixel, // Pixel read from frame memory.
  input wire [PIXEL_WIDTH-1:0] display_off_value, // Display-off output value.
  input wire fm_access_req, // Processor or DMA frame memory access.
  output reg draw_reset, // Drawing engine reset level.
  output reg draw_run_enable, // Command processing allowed.
  output reg render_go, // Render start passed to drawing engine.
  output reg render_break_out, // Render break request to engine.
  output reg refresh_only, // Frame memory refresh-only mode.
  output reg [PIXEL_WIDTH-1:0] display_data, // Display data output.
  output reg fm_wait, // Wait to frame memory accesses.
  output reg soft_reset_held // Soft reset held long enough.
);
  // Stored control bits.
  reg drawing_soft_reset;
  reg display_reset_ctl;
  reg display_output_enable;
  reg render_break_request;
  reg display_change;
  reg render_start_bit;
  reg burst_mode_hi;
  reg burst_mode_lo;
  reg [5:0] low_ctl; // Lower DMA and access fields.
  // Drawing status flags.
  reg command_error_flag;
  reg trap_flag;
  reg command_suspend_flag;
  reg drawing_break_flag;
  reg vertical_blank_flag;
  // Display configuration.
  reg video_capture_enable;
  // Display output source chosen at frame start.
  reg show_frame;
  // Burst bits have no async reset; they load a constant while burst_init is low, after every reset.
  reg burst_init;
  // Answer phase of the bus slave.
  reg answered;
  wire frame_start;
  wire vblank_raw;
  wire hold_done;
  wire wr_go;
  wire rd_go;
  wire [1:0] dstate;
  // A write lands at the edge where waitrequest is seen low, the one edge at which the
  // master still holds address and data and counts the transfer as done.
  assign wr_go = avs_write && answered;
  assign rd_go = avs_read && !answered;
  assign dstate = {display_reset_ctl, display_output_enable};
  // Frame timing for the display path.
  frame_sync #(
    .FRAME_CYCLES(FRAME_CYCLES)
  ) u_frame (
    .clk(clk),
    .arst_n(arst_n),
    .run(!display_reset_ctl),
    .frame_start(frame_start),
    .vblank(vblank_raw)
  );
  // Hold time watch on the soft reset.
  soft_reset_timer #(
    .MIN_CYCLES(`SOFT_RESET_MIN_CYCLES)
  ) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .hold(drawing_soft_reset),
    .done(hold_done)
  );
  // Bus handshake: waitrequest drops for one cycle to answer each request.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      answered <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else if ((avs_read || avs_write) && !answered)
    begin
      answered <= 1'b1;
      avs_waitrequest <= 1'b0;
    end
    else
    begin
      answered <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
  end
  // Read data mux; unmapped addresses read zero.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      avs_readdata <= 32'h00000000;
    else if (rd_go)
    begin
      case (avs_address)
        `ADDR_SYSTEM_CONTROL:
          avs_readdata <= {16'h0000, drawing_soft_reset, display_reset_ctl,
            display_output_enable, 2'b00, render_break_request, display_change,
            render_start_bit, burst_mode_hi, burst_mode_lo, low_ctl};
        `ADDR_DRAW_STATUS:
          avs_readdata <= {27'h0000000, vertical_blank_flag, drawing_break_flag,
            command_suspend_flag, trap_flag, command_error_flag};
        `ADDR_DISPLAY_CFG:
          avs_readdata <= {31'h00000000, video_capture_enable};
        `ADDR_DISPLAY_STATE:
          avs_readdata <= {29'h00000000, hold_done, dstate};
        default:
          avs_readdata <= 32'h00000000;
      endcase
    end
  end
  // System control register storage.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drawing_soft_reset <= 1'b1;
      display_reset_ctl <= 1'b1;
      display_output_enable <= 1'b0;
      render_break_request <= 1'b0;
      display_change <= 1'b0;
      render_start_bit <= 1'b0;
      low_ctl <= 6'h00;
    end
    else
    begin
      if (wr_go && avs_address == `ADDR_SYSTEM_CONTROL)
      begin
        drawing_soft_reset <= avs_writedata[`BIT_SOFT_RESET];
        display_output_enable <= avs_writedata[`BIT_DISPLAY_ENABLE];
        display_reset_ctl <= avs_writedata[`BIT_DISPLAY_RESET] || !reset_pin_n;
        render_start_bit <= avs_writedata[`BIT_RENDER_START];
        display_change <= avs_writedata[`BIT_DISPLAY_CHANGE];
        render_break_request <= avs_writedata[`BIT_RENDER_BREAK];
        low_ctl <= avs_writedata[5:0];
      end
      else
      begin
        if (!reset_pin_n)
          display_reset_ctl <= 1'b1;
        // Start and change bits clear once the engine acts.
        if (render_started)
          render_start_bit <= 1'b0;
        if (display_changed)
          display_change <= 1'b0;
        if (draw_break_evt)
          render_break_request <= 1'b0;
      end
      if (drawing_soft_reset)
        render_break_request <= 1'b0;
    end
  end
  // Burst bits load zero on each clock while burst_init is low, so after every reset.
  always @(posedge clk)
  begin
    if (!burst_init)
    begin
      burst_mode_hi <= 1'b0;
      burst_mode_lo <= 1'b0;
    end
    else if (wr_go && avs_address == `ADDR_SYSTEM_CONTROL)
    begin
      burst_mode_hi <= avs_writedata[`BIT_BURST_HI];
      burst_mode_lo <= avs_writedata[`BIT_BURST_LO];
    end
  end
  // Marks that burst bits have been given a start value.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      burst_init <= 1'b0;
    else
      burst_init <= 1'b1;
  end
  // Status flags: events set, soft reset clears all but vblank, write of 1 clears.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      command_error_flag <= 1'b0;
      trap_flag <= 1'b0;
      command_suspend_flag <= 1'b0;
      drawing_break_flag <= 1'b0;
      vertical_blank_flag <= 1'b0;
    end
    else if (drawing_soft_reset)
    begin
      command_error_flag <= 1'b0;
      trap_flag <= 1'b0;
      command_suspend_flag <= 1'b0;
      drawing_break_flag <= 1'b0;
      vertical_blank_flag <= (dstate == `DSTATE_REFRESH) ? 1'b0 :
        (vertical_blank_flag || vblank_raw);
    end
    else
    begin
      if (wr_go && avs_address == `ADDR_DRAW_STATUS)
      begin
        // Set wins over a simultaneous clear.
        command_error_flag <= cmd_error_evt ||
          (command_error_flag && !avs_writedata[`BIT_CMD_ERROR]);
        trap_flag <= trap_evt || (trap_flag && !avs_writedata[`BIT_TRAP]);
        command_suspend_flag <= cmd_suspend_evt ||
          (command_suspend_flag && !avs_writedata[`BIT_CMD_SUSPEND]);
        drawing_break_flag <= draw_break_evt ||
          (drawing_break_flag && !avs_writedata[`BIT_DRAW_BREAK]);
      end
      else
      begin
        command_error_flag <= command_error_flag || cmd_error_evt;
        trap_flag <= trap_flag || trap_evt;
        command_suspend_flag <= command_suspend_flag || cmd_suspend_evt;
        drawing_break_flag <= drawing_break_flag || draw_break_evt;
      end
      if (dstate == `DSTATE_REFRESH)
        vertical_blank_flag <= 1'b0;
      else if (wr_go && avs_address == `ADDR_DRAW_STATUS &&
          avs_writedata[`BIT_VBLANK])
        vertical_blank_flag <= vblank_raw;
      else
        vertical_blank_flag <= vertical_blank_flag || vblank_raw;
    end
  end
  // Display configuration register.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      video_capture_enable <= 1'b0;
    else if (wr_go && avs_address == `ADDR_DISPLAY_CFG)
      video_capture_enable <= avs_writedata[`BIT_CAPTURE_EN];
  end
  // Display source switches to frame memory only at a frame start.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      show_frame <= 1'b0;
    else if (dstate != `DSTATE_RUN_ON)
      show_frame <= 1'b0;
    else if (frame_start)
      show_frame <= 1'b1;
  end
  // Drawing engine controls.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      draw_reset <= 1'b1;
      draw_run_enable <= 1'b0;
      render_go <= 1'b0;
      render_break_out <= 1'b0;
      soft_reset_held <= 1'b0;
    end
    else
    begin
      draw_reset <= drawing_soft_reset;
      draw_run_enable <= !drawing_soft_reset;
      render_go <= render_start_bit && !drawing_soft_reset && !display_reset_ctl;
      render_break_out <= render_break_request;
      soft_reset_held <= hold_done;
    end
  end
  // Display outputs by display state.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      display_data <= {PIXEL_WIDTH{1'b0}};
      refresh_only <= 1'b1;
      fm_wait <= 1'b0;
    end
    else
    begin
      case (dstate)
        `DSTATE_RUN_OFF:
        begin
          display_data <= display_off_value;
          refresh_only <= 1'b0;
          fm_wait <= 1'b0;
        end
        `DSTATE_RUN_ON:
        begin
          display_data <= show_frame ? frame_pixel : display_off_value;
          refresh_only <= 1'b0;
          fm_wait <= 1'b0;
        end
        `DSTATE_REFRESH:
        begin
          refresh_only <= 1'b1;
          display_data <= {PIXEL_WIDTH{1'b0}};
          fm_wait <= fm_access_req && !video_capture_enable;
        end
        default:
        begin
          refresh_only <= 1'b1;
          display_data <= {PIXEL_WIDTH{1'b0}};
          fm_wait <= fm_access_req && !video_capture_enable;
        end
      endcase
    end
  end
endmodule // drawing_display_reset_control

// ==== avalon_host_model.sv ====
// Host processor model: an Avalon-MM master for the control registers.
module avalon_host_model (
  input wire logic clk, // System clock.
  input wire logic avs_waitrequest, // Slave wait, low when answered.
  input wire logic [31:0] avs_readdata, // Slave read data.
  output logic [3:0] avs_address, // Word address.
  output logic avs_read, // Read request.
  output logic avs_write, // Write request.
  output logic [31:0] avs_writedata // Write data.
);
  timeunit 1ns;
  timeprecision 1ns;

  // The bus idles with no request from time zero.
  initial
  begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end

  // Holds one request until waitrequest is sampled low, then releases it.
  // Released address and data turn over, so nothing stale looks valid.
  task automatic access(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic ok);
    int n;
    begin
      ok = 1'b0;
      rdata = 32'h0;
      @(posedge clk);
      avs_address <= addr;
      avs_writedata <= (addr == 4'h0) ? (wdata & 32'hFFFF_E7FF) : wdata;
      avs_write <= wr;
      avs_read <= !wr;
      for (n = 0; n < 20 && !ok; n++)
      begin
        @(posedge clk);
        if (avs_waitrequest === 1'b0)
        begin
          rdata = avs_readdata;
          ok = 1'b1;
          avs_write <= 1'b0;
          avs_read <= 1'b0;
          avs_address <= ~addr;
          avs_writedata <= ~wdata;
        end
      end
    end
  endtask
endmodule // avalon_host_model

// ==== drawing_display_reset_control_chk.sv ====
// Watches the control block's ports for the drawing and display reset rules.
module drawing_display_reset_control_chk #(
  parameter FRAME_CYCLES = 1024,
  parameter PIXEL_WIDTH = 16
) (
  input wire logic clk, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic reset_pin_n, // Hardware reset pin, active low.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic avs_waitrequest, // Slave wait.
  input wire logic draw_reset, // Drawing reset level.
  input wire logic draw_run_enable, // Command processing allowed.
  input wire logic render_go, // Render start to the engine.
  input wire logic render_break_out, // Render break to the engine.
  input wire logic refresh_only, // Refresh-only display state.
  input wire logic [PIXEL_WIDTH-1:0] display_data, // Display output.
  input wire logic soft_reset_held // Soft reset hold reached.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] hold_cnt; // Consecutive cycles with drawing reset high.

  // Counts how long the drawing reset has stood, saturating at 31.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      hold_cnt <= 5'h0;
    else if (!draw_reset)
      hold_cnt <= 5'h0;
    else if (hold_cnt != 5'h1F)
      hold_cnt <= hold_cnt + 5'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Refresh-only state has stood long enough for every output to follow.
  sequence s_refresh_settled;
    refresh_only [*3];
  endsequence
  // Drawing reset has stood long enough for the break bit to clear.
  sequence s_draw_held;
    draw_reset [*2];
  endsequence

  a_run_inverse: assert property (draw_run_enable != draw_reset)
    else $error("run enable is not the inverse of drawing reset");
  a_refresh_zero_data: assert property (s_refresh_settled |-> display_data == '0)
    else $error("display data not zero in refresh-only state");
  a_refresh_no_draw: assert property (s_refresh_settled |-> !render_go)
    else $error("render start passed in refresh-only state");
  a_break_cleared: assert property (s_draw_held |-> !render_break_out)
    else $error("render break survives soft reset");
  a_pin_holds_display: assert property ((!reset_pin_n) [*3] |-> refresh_only)
    else $error("display reset dropped while reset pin low");
  a_reset_state: assert property ($rose(arst_n) |-> draw_reset && refresh_only)
    else $error("wrong state after reset");
  a_hold_min_time: assert property ($rose(soft_reset_held) |-> hold_cnt >= 5'd14)
    else $error("hold flag rose too early");
  a_hold_max_time: assert property (hold_cnt == 5'h1F |-> soft_reset_held)
    else $error("hold flag missing after long hold");
  a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  a_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule // drawing_display_reset_control_chk

bind drawing_display_reset_control drawing_display_reset_control_chk #(
  .FRAME_CYCLES(FRAME_CYCLES),
  .PIXEL_WIDTH(PIXEL_WIDTH)
) chk_inst (
  .clk(clk), .arst_n(arst_n), .reset_pin_n(reset_pin_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .draw_reset(draw_reset),
  .draw_run_enable(draw_run_enable), .render_go(render_go),
  .render_break_out(render_break_out), .refresh_only(refresh_only),
  .display_data(display_data), .soft_reset_held(soft_reset_held)
);

// ==== drawing_display_reset_control_tb.sv ====
// Self-checking bench for the drawing and display reset control bits.
module drawing_display_reset_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FRAME = 16; // Short frame keeps the run brief.
  logic clk, arst_n, reset_pin_n; // Clock and resets.
  logic [3:0] avs_address; // Bus address.
  logic avs_read, avs_write, avs_waitrequest; // Bus handshake.
  logic [31:0] avs_writedata, avs_readdata; // Bus data.
  logic cmd_error_evt, trap_evt, cmd_suspend_evt, draw_break_evt; // Engine events.
  logic render_started, display_changed; // Engine acknowledges, kept idle.
  logic [15:0] frame_pixel, display_off_value; // Pixel sources.
  logic fm_access_req, draw_reset, draw_run_enable, render_go; // Control lines.
  logic render_break_out, refresh_only, fm_wait, soft_reset_held; // Status lines.
  logic [15:0] display_data; // Display output.
  int failures; // Mismatches seen.
  int compares; // Comparisons made.

  drawing_display_reset_control #(.FRAME_CYCLES(FRAME), .PIXEL_WIDTH(16))
  drawing_display_reset_control_inst (
    .clk(clk), .arst_n(arst_n), .reset_pin_n(reset_pin_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmd_error_evt(cmd_error_evt), .trap_evt(trap_evt), .cmd_suspend_evt(cmd_suspend_evt),
    .draw_break_evt(draw_break_evt), .render_started(render_started),
    .display_changed(display_changed), .frame_pixel(frame_pixel),
    .display_off_value(display_off_value), .fm_access_req(fm_access_req),
    .draw_reset(draw_reset), .draw_run_enable(draw_run_enable), .render_go(render_go),
    .render_break_out(render_break_out), .refresh_only(refresh_only),
    .display_data(display_data), .fm_wait(fm_wait), .soft_reset_held(soft_reset_held));

  avalon_host_model avalon_host_model_inst (
    .clk(clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata));

  // Free-running 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Prints the verdict and ends the run.
  task automatic stop_test;
    begin
      if (failures == 0 && compares > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      compares++;
      if (got !== exp)
      begin
        failures++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  // One bus access; a hung bus ends the run as a failure.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    logic ok;
    begin
      avalon_host_model_inst.access(wr, a, d, r, ok);
      if (ok !== 1'b1)
      begin
        failures++;
        stop_test();
      end
    end
  endtask

  // Register write.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    begin
      bus(1'b1, a, d, r);
    end
  endtask

  // Register read compared under a mask.
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] r;
    begin
      bus(1'b0, a, 32'h0, r);
      check(what, exp, r & m);
    end
  endtask

  // Lets outputs settle, then samples away from the active edge.
  task automatic settle(input int n);
    begin
      repeat (n) @(posedge clk);
      @(negedge clk);
    end
  endtask

  // One cycle pulse on all four engine events.
  task automatic pulse_events;
    begin
      @(posedge clk);
      {cmd_error_evt, trap_evt, cmd_suspend_evt, draw_break_evt} <= 4'hF;
      @(posedge clk);
      {cmd_error_evt, trap_evt, cmd_suspend_evt, draw_break_evt} <= 4'h0;
    end
  endtask

  // Main sequence of scenarios.
  initial
  begin
    int n;
    failures = 0;
    compares = 0;
    arst_n = 1'b0;
    reset_pin_n = 1'b1;
    {cmd_error_evt, trap_evt, cmd_suspend_evt, draw_break_evt} = 4'h0;
    render_started = 1'b0;
    display_changed = 1'b0;
    frame_pixel = 16'hA5C3;
    display_off_value = 16'h3C5A;
    fm_access_req = 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    settle(1);
    check("draw_reset", 32'h1, draw_reset);
    check("refresh_only", 32'h1, refresh_only);
    rd_chk("system_control", 4'h0, 32'hFFFF_FFFF, 32'h0000_C000);
    rd_chk("unmapped", 4'hF, 32'hFFFF_FFFF, 32'h0);
    // Display reset cannot be cleared while the pin is low.
    reset_pin_n <= 1'b0;
    wr(4'h0, 32'h0);
    rd_chk("system_control", 4'h0, 32'hFFFF_FFFF, 32'h0000_4000);
    reset_pin_n <= 1'b1;
    settle(2);
    check("draw_run_enable", 32'h1, draw_run_enable);
    // Blank output with render start granted.
    wr(4'h2, 32'h0);
    wr(4'h0, 32'h0000_0100);
    settle(3);
    check("display_data", display_off_value, display_data);
    check("render_go", 32'h1, render_go);
    // display reset cleared before output enable
    wr(4'h0, 32'h0000_2000);
    for (n = 0; n < 4 * FRAME && display_data !== frame_pixel; n++)
      @(negedge clk);
    check("display_data", frame_pixel, display_data);
    rd_chk("system_control", 4'h0, 32'h0000_E000, 32'h0000_2000);
    rd_chk("vblank", 4'h1, 32'h0000_0010, 32'h0000_0010);
    // Soft reset clears drawing flags while the display keeps running.
    pulse_events();
    rd_chk("status", 4'h1, 32'h0000_000F, 32'h0000_000F);
    wr(4'h0, 32'h0000_2400);
    settle(3);
    check("render_break_out", 32'h1, render_break_out);
    wr(4'h0, 32'h0000_A000);
    settle(3);
    check("render_break_out", 32'h0, render_break_out);
    rd_chk("status", 4'h1, 32'h0000_000F, 32'h0);
    pulse_events();
    rd_chk("status", 4'h1, 32'h0000_000F, 32'h0);
    rd_chk("system_control", 4'h0, 32'h0000_E400, 32'h0000_A000);
    check("display_data", frame_pixel, display_data);
    for (n = 0; n < 40 && soft_reset_held !== 1'b1; n++)
      @(negedge clk);
    check("soft_reset_held", 32'h1, soft_reset_held);
    wr(4'h0, 32'h0000_2000);
    settle(3);
    check("draw_run_enable", 32'h1, draw_run_enable);
    // Display on to refresh-only, with render start and a pending access.
    fm_access_req <= 1'b1;
    wr(4'h0, 32'h0000_4100);
    settle(3);
    check("refresh_only", 32'h1, refresh_only);
    check("render_go", 32'h0, render_go);
    check("display_data", 32'h0, display_data);
    check("fm_wait", 32'h1, fm_wait);
    rd_chk("display_state", 4'h3, 32'h0000_0003, 32'h0000_0002);
    for (n = 0; n < 8; n++)
      rd_chk("vblank", 4'h1, 32'h0000_0010, 32'h0);
    wr(4'h2, 32'h0000_0001);
    settle(3);
    check("fm_wait", 32'h0, fm_wait);
    stop_test();
  end
endmodule // drawing_display_reset_control_tb
